/* File: hdl/pis_store.sv */
/*
 * read-only processor info store at byte offsets 14h..22h, one byte per bus word.
 * assumes an axi4-lite master on aclk with one write and one read in flight at most.
 */
// The AXI4-Lite register port was chosen for this implementation.
// Operation
// - sample byte: low two bits 00 sample, 01 production; rest zero
// - every write is ignored; stored contents never change
// - offset 15h holds the one-byte processor data checksum
// - signature field holds signature bits 13:0 shifted left by two
// - signature high byte at 16h, low byte at 17h
// - type 15:14, family 13:10, model 9:6, stepping 5:2, 1:0 reserved
// - bus speed at 1Ah-1Bh in whole MHz, 029Bh or 0320h
// - multiprocessor class in bits 7:6, lower six bits reserved
// - maximum core frequency at 1Dh-1Eh in whole MHz
// - maximum core voltage code at 1Fh-20h in millivolts
// - minimum core voltage at 21h-22h in millivolts
// - bytes 18h-19h are reserved, read as zero
`timescale 1ns/1ps
module pis_store #(
    parameter logic [1:0] SAMPLE_CODE = pis_pkg::SAMPLE_PROD,
    parameter logic [7:0] CHECKSUM = 8'h00,
    // signature parts: values are arbitrary
    parameter logic [1:0] SIG_TYPE = 2'h0,
    parameter logic [3:0] SIG_FAMILY = 4'h1,
    parameter logic [3:0] SIG_MODEL = 4'h2,
    parameter logic [3:0] SIG_STEPPING = 4'h3,
    parameter logic [15:0] BUS_SPEED = pis_pkg::BUS_800,
    parameter logic [1:0] MP_CLASS = pis_pkg::MP_MANY,
    parameter logic [15:0] MAX_FREQ = pis_pkg::FREQ_3400,
    parameter logic [15:0] MAX_VCODE = pis_pkg::VMAX_1350,
    parameter logic [15:0] MIN_VOLT = pis_pkg::VMIN_991
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [pis_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [pis_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [pis_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [pis_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // store contents

    // 16-bit signature, reserved low pair
    localparam logic [15:0] SIGNATURE = {SIG_TYPE, SIG_FAMILY, SIG_MODEL, SIG_STEPPING,
                                         pis_pkg::SIG_RSVD};

    function automatic logic in_store(input logic [pis_pkg::IDX_W-1:0] idx);
        in_store = (idx >= pis_pkg::IDX_SAMPLE) && (idx <= pis_pkg::IDX_VMIN_LO);
    endfunction

    // pure function of the index: nothing can alter it, so repeats match
    function automatic pis_pkg::pis_rd_t store_read(input logic [pis_pkg::IDX_W-1:0] idx);
        logic [7:0] b;
        b = pis_pkg::BYTE_ZERO;
        case (idx)
            pis_pkg::IDX_SAMPLE: b = {pis_pkg::SAMPLE_RSVD, SAMPLE_CODE};
            pis_pkg::IDX_CHECKSUM: b = CHECKSUM;
            pis_pkg::IDX_SIG_HI: b = SIGNATURE[15:8];
            pis_pkg::IDX_SIG_LO: b = SIGNATURE[7:0];
            pis_pkg::IDX_RSVD_HI: b = pis_pkg::RSVD_PAIR[15:8];
            pis_pkg::IDX_RSVD_LO: b = pis_pkg::RSVD_PAIR[7:0];
            pis_pkg::IDX_BUS_HI: b = BUS_SPEED[15:8];
            pis_pkg::IDX_BUS_LO: b = BUS_SPEED[7:0];
            pis_pkg::IDX_MP: b = {MP_CLASS, pis_pkg::MP_RSVD};
            pis_pkg::IDX_FREQ_HI: b = MAX_FREQ[15:8];
            pis_pkg::IDX_FREQ_LO: b = MAX_FREQ[7:0];
            pis_pkg::IDX_VMAX_HI: b = MAX_VCODE[15:8];
            pis_pkg::IDX_VMAX_LO: b = MAX_VCODE[7:0];
            pis_pkg::IDX_VMIN_HI: b = MIN_VOLT[15:8];
            pis_pkg::IDX_VMIN_LO: b = MIN_VOLT[7:0];
            default: b = pis_pkg::BYTE_ZERO;
        endcase
        store_read.data = {24'h000000, b};
        store_read.resp = in_store(idx) ? pis_pkg::RESP_OKAY : pis_pkg::RESP_SLVERR;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // write channel: accept both halves in either order, then answer

    pis_pkg::pis_wstate_t wstate_reg;
    pis_pkg::pis_wstate_t wstate_next;
    logic [pis_pkg::IDX_W-1:0] widx_reg;
    logic aw_hs;
    logic w_hs;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;

    always_comb begin
        wstate_next = wstate_reg;
        case (wstate_reg)
            pis_pkg::W_IDLE: begin
                if (aw_hs && w_hs) begin
                    wstate_next = pis_pkg::W_RESP;
                end else if (aw_hs) begin
                    wstate_next = pis_pkg::W_HAVE_ADDR;
                end else if (w_hs) begin
                    wstate_next = pis_pkg::W_HAVE_DATA;
                end
            end
            pis_pkg::W_HAVE_ADDR: begin
                if (w_hs) begin
                    wstate_next = pis_pkg::W_RESP;
                end
            end
            pis_pkg::W_HAVE_DATA: begin
                if (aw_hs) begin
                    wstate_next = pis_pkg::W_RESP;
                end
            end
            pis_pkg::W_RESP: begin
                if (s_axi_bready) begin
                    wstate_next = pis_pkg::W_IDLE;
                end
            end
            default: wstate_next = pis_pkg::W_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_reg <= pis_pkg::W_IDLE;
        end else begin
            wstate_reg <= wstate_next;
        end
    end

    // address kept only to pick the response; data is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            widx_reg <= '0;
        end else if (aw_hs) begin
            widx_reg <= s_axi_awaddr[pis_pkg::IDX_LSB +: pis_pkg::IDX_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= (wstate_next == pis_pkg::W_IDLE) ||
                             (wstate_next == pis_pkg::W_HAVE_DATA);
            s_axi_wready <= (wstate_next == pis_pkg::W_IDLE) ||
                            (wstate_next == pis_pkg::W_HAVE_ADDR);
        end
    end

    // writes touch no storage; in-store writes answer okay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pis_pkg::RESP_OKAY;
        end else begin
            s_axi_bvalid <= (wstate_next == pis_pkg::W_RESP);
            if (wstate_reg != pis_pkg::W_RESP && wstate_next == pis_pkg::W_RESP) begin
                if (in_store(aw_hs ? s_axi_awaddr[pis_pkg::IDX_LSB +: pis_pkg::IDX_W]
                                   : widx_reg)) begin
                    s_axi_bresp <= pis_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= pis_pkg::RESP_SLVERR;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, answer one cycle after the address

    pis_pkg::pis_rd_t rd_next;
    logic ar_hs;

    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_next = store_read(s_axi_araddr[pis_pkg::IDX_LSB +: pis_pkg::IDX_W]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b0;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= pis_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rdata <= rd_next.data;
            s_axi_rresp <= rd_next.resp;
        end
    end

endmodule

/* File: hdl/pis_pkg.sv */
/*
 * constants, field layouts and carrier types of the processor info store.
 * assumes a 32-bit axi4-lite register bus with byte addresses on 8 bits.
 */
package pis_pkg;

    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;

    // byte offsets of the store, used as word indices
    localparam logic [IDX_W-1:0] IDX_SAMPLE = 6'h14;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM = 6'h15;
    localparam logic [IDX_W-1:0] IDX_SIG_HI = 6'h16;
    localparam logic [IDX_W-1:0] IDX_SIG_LO = 6'h17;
    localparam logic [IDX_W-1:0] IDX_RSVD_HI = 6'h18;
    localparam logic [IDX_W-1:0] IDX_RSVD_LO = 6'h19;
    localparam logic [IDX_W-1:0] IDX_BUS_HI = 6'h1A;
    localparam logic [IDX_W-1:0] IDX_BUS_LO = 6'h1B;
    localparam logic [IDX_W-1:0] IDX_MP = 6'h1C;
    localparam logic [IDX_W-1:0] IDX_FREQ_HI = 6'h1D;
    localparam logic [IDX_W-1:0] IDX_FREQ_LO = 6'h1E;
    localparam logic [IDX_W-1:0] IDX_VMAX_HI = 6'h1F;
    localparam logic [IDX_W-1:0] IDX_VMAX_LO = 6'h20;
    localparam logic [IDX_W-1:0] IDX_VMIN_HI = 6'h21;
    localparam logic [IDX_W-1:0] IDX_VMIN_LO = 6'h22;

    // sample/production codes, low two bits
    localparam logic [1:0] SAMPLE_ENG = 2'h0;
    localparam logic [1:0] SAMPLE_PROD = 2'h1;
    localparam logic [5:0] SAMPLE_RSVD = 6'h00;

    // multiprocessor class codes, high two bits
    localparam logic [1:0] MP_UNI = 2'h0;
    localparam logic [1:0] MP_DUAL = 2'h1;
    localparam logic [1:0] MP_MANY = 2'h3;
    localparam logic [5:0] MP_RSVD = 6'h00;

    // signature layout
    localparam logic [1:0] SIG_RSVD = 2'h0;

    // coded values
    localparam logic [15:0] BUS_667 = 16'h029B;
    localparam logic [15:0] BUS_800 = 16'h0320;
    localparam logic [15:0] FREQ_3400 = 16'h0D48;
    localparam logic [15:0] VMAX_1350 = 16'h0546;
    localparam logic [15:0] VMIN_991 = 16'h03DF;
    localparam logic [15:0] RSVD_PAIR = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // read answer carrier
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0] resp;
    } pis_rd_t;

    // write channel states
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_HAVE_ADDR = 2'b01,
        W_HAVE_DATA = 2'b10,
        W_RESP = 2'b11
    } pis_wstate_t;

endpackage

/* File: dv/pis_monitor.sv */
/*
 * read- and write-side checks of the processor info store.
 * assumes binding to pis_store; word address bits 7:2 give the byte offset.
 */
`timescale 1ns/1ps
module pis_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [pis_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [pis_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [5:0] idx_reg;
    // offset of the read in flight
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            idx_reg <= s_axi_araddr[7:2];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bytes set");
    property p_sample;
        s_axi_rvalid && idx_reg == 6'h14 |-> s_axi_rdata[7:1] == 7'h00;
    endproperty
    a_sample: assert property (p_sample) else $error("bad sample code");
    property p_mp;
        s_axi_rvalid && idx_reg == 6'h1C |-> s_axi_rdata[5:0] == 6'h00 && s_axi_rdata[7:6] != 2'h2;
    endproperty
    a_mp: assert property (p_mp) else $error("bad multiprocessor class");
    property p_rsvd;
        s_axi_rvalid && idx_reg[5:1] == 5'h0C |-> s_axi_rdata[7:0] == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved pair not zero");
    property p_sig_low;
        s_axi_rvalid && idx_reg == 6'h17 |-> s_axi_rdata[1:0] == 2'h0;
    endproperty
    a_sig_low: assert property (p_sig_low) else $error("signature low bits set");
    property p_bus_hi;
        s_axi_rvalid && idx_reg == 6'h1A |-> s_axi_rdata[7:1] == 7'h01;
    endproperty
    a_bus_hi: assert property (p_bus_hi) else $error("bad bus speed high byte");
    property p_latency;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_latency: assert property (p_latency) else $error("read answer late");
    property p_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read answer dropped");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule

/* File: dv/testbench.sv */
/*
 * self-checking bench of the processor info store over axi4-lite.
 * assumes pis_store with default parameters; checks derive from the rules.
 */
`timescale 1ns/1ps
module testbench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [7:0] got [15];
    int failures, checks_done;
    pis_store dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ready sampled mid-cycle, so the handshake edge is the next rising one
    task automatic wr(input logic [7:0] a, output logic [1:0] rs);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= 32'hFFFF_FFFF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) break;
        end
        bready <= 1'b0;
    endtask
    // stall holds rready low to make the slave keep its answer
    task automatic rd(input logic [7:0] a, input int stall, output logic [31:0] dt,
        output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (stall == 0);
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            if (arready) break;
        end
        @(posedge aclk);
        arvalid <= 1'b0;
        repeat (stall) @(posedge aclk);
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            if (rvalid) break;
        end
        dt = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_fields;
        logic [15:0] sig;
        for (int i = 0; i < 15; i++) begin
            rd(8'((i + 20) * 4), 0, d, r);
            got[i] = d[7:0];
            chk(r, pis_pkg::RESP_OKAY, "read resp");
        end
        sig = {got[2], got[3]};
        chk(got[0], {6'h00, pis_pkg::SAMPLE_PROD}, "sample");
        chk(got[1], 8'h00, "checksum");
        chk(sig, {2'h0, 4'h1, 4'h2, 4'h3, 2'h0}, "signature");
        chk(sig[1:0], 2'h0, "signature low bits");
        chk(sig[13:10], 4'h1, "family");
        chk(sig >> 2, 14'h0123, "signature shifted");
        chk({got[4], got[5]}, 16'h0000, "reserved pair");
        chk({got[6], got[7]}, pis_pkg::BUS_800, "bus speed");
        chk(got[8], 8'hC0, "mp class");
        chk({got[9], got[10]}, pis_pkg::FREQ_3400, "max freq");
        chk({got[11], got[12]}, pis_pkg::VMAX_1350, "max vcode");
        chk({got[13], got[14]}, pis_pkg::VMIN_991, "min volt");
    endtask
    task automatic test_writes_ignored;
        for (int i = 0; i < 15; i++) begin
            wr(8'((i + 20) * 4), r);
            chk(r, pis_pkg::RESP_OKAY, "write resp");
        end
        for (int i = 0; i < 15; i++) begin
            rd(8'((i + 20) * 4), 2, d, r);
            chk(d, {24'h0, got[i]}, "reread");
        end
    endtask
    task automatic test_unmapped;
        wr(8'h00, r);
        chk(r, pis_pkg::RESP_SLVERR, "unmapped write");
        rd(8'hFC, 1, d, r);
        chk(d, 32'h0000_0000, "unmapped read data");
        chk(32'(r), 32'(pis_pkg::RESP_SLVERR), "unmapped read resp");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        report_and_stop();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        test_fields();
        test_writes_ignored();
        test_unmapped();
        report_and_stop();
    end
endmodule
bind pis_store pis_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
